// ---- include/exec_pkg.sv ----
// Constants and operation codes for the branch, skip, bit and shift execution unit
package exec_pkg;

    // ------------------------------------------------------------------
    // Status flag positions
    // ------------------------------------------------------------------
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_H = 5;
    localparam int unsigned FLAG_T = 6;
    localparam int unsigned FLAG_I = 7;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL  = 12'h000;
    localparam logic [11:0] OFS_PC    = 12'h004;
    localparam logic [11:0] OFS_FLAGS = 12'h008;
    localparam logic [11:0] OFS_STAT  = 12'h00C;

    localparam int unsigned CTRL_EN_POS = 0;
    localparam logic        CTRL_RST    = 1'b1;
    localparam logic [7:0]  FLAGS_RST   = 8'h00;

    // ------------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------------
    localparam logic [1:0] CYC_ONE   = 2'h1;
    localparam logic [1:0] CYC_TWO   = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    // ------------------------------------------------------------------
    // Operation codes presented by the decoder
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        op_nop,
        compare_immediate,
        skip_reg_bit_low, skip_reg_bit_high,
        skip_io_bit_low, skip_io_bit_high,
        branch_flag_one, branch_flag_zero,
        branch_equal, branch_not_equal,
        branch_carry_one, branch_carry_zero,
        branch_same_higher, branch_lower,
        branch_minus, branch_plus,
        branch_signed_ge, branch_signed_less,
        branch_halfcarry_one, branch_halfcarry_zero,
        branch_xfer_one, branch_xfer_zero,
        branch_overflow_one,
        branch_int_on, branch_int_off,
        io_bit_force_one, io_bit_force_zero,
        shift_left_logical, shift_right_logical,
        rotate_left_carry, rotate_right_carry,
        shift_right_arith, swap_nibbles,
        flag_force_one, flag_force_zero,
        reg_bit_to_xfer, xfer_to_reg_bit
    } op_t;

endpackage : exec_pkg

// ---- src/branch_skip_bit_shift_exec.sv ----
// Execution unit for compare, skip, branch, bit, shift and flag instructions
//
// Contract
// - Compare immediate subtracts without storing, updates Z N V C H, one cycle.
// - Register bit skips skip on bit clear or set, PC plus 2 or 3.
// - I/O bit skips test the port bit and skip, flags untouched.
// - Branch on flag one loads PC plus k plus one; 1 or 2 cycles.
// - Branch on flag zero branches when bit clear, else sequential, flags untouched.
// - Dedicated branches on Z, C and N being one or zero.
// - Signed branches test N xor V: zero for ge, one for less.
// - Half carry branches on H one or zero.
// - Transfer flag branches on T one or zero, 1 or 2 cycles.
// - Overflow branch to PC plus k plus one when V is one.
// - Interrupt state branches on I one or zero.
// - Force I/O bit one, other bits and flags kept, two cycles.
// - Force I/O bit zero, other bits and flags kept, two cycles.
// - Rotate left: C into bit 0, bit 7 into C, Z C N V, one cycle.
// - Rotate right: C into bit 7, bit 0 into C, Z C N V, one cycle.
// - Arithmetic right shift keeps bit 7, updates Z C N V, one cycle.
// - Bit store copies selected register bit into T, one cycle.
// - Bit load copies T into selected register bit, flags kept, one cycle.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

module branch_skip_bit_shift_exec #(
    parameter int unsigned PC_W = 16
) (
    // Clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_sys_rst,
    // Decoded instruction
    input  wire logic                 i_issue,
    input  wire exec_pkg::op_t        i_op,
    input  wire logic [2:0]           i_bit_sel,
    input  wire logic [7:0]           i_reg_data,
    input  wire logic [7:0]           i_imm,
    input  wire logic [6:0]           i_offset,
    input  wire logic                 i_next_two_word,
    input  wire logic [7:0]           i_io_rdata,
    output logic                      o_ready,
    // Register file and I/O write back
    output logic                      o_rf_we,
    output logic [7:0]                o_rf_wdata,
    output logic                      o_io_we,
    output logic [7:0]                o_io_wdata,
    // Core state
    output logic [PC_W-1:0]           o_pc,
    output logic [7:0]                o_flags,
    output logic [1:0]                o_cycles,
    // APB slave
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [11:0]          i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic [31:0]               o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic                 en_q;
    logic [1:0]           rem_q;
    exec_pkg::op_t        last_op_q;
    logic                 iss;
    logic                 apb_wr;
    logic                 mapped;

    // ------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------
    logic [7:0]           flags_d;
    logic [7:0]           res_d;
    logic                 rf_we_d;
    logic                 io_we_d;
    logic [7:0]           io_wdata_d;
    logic [PC_W-1:0]      pc_d;
    logic [1:0]           cyc_d;
    logic                 br_op;
    logic                 br_cond;
    logic                 sk_op;
    logic                 sk_cond;
    logic [8:0]           diff;
    logic [PC_W-1:0]      k_ext;

    assign iss    = i_issue & o_ready & en_q;
    assign apb_wr = i_psel & i_penable & o_pready & i_pwrite;
    assign mapped = (i_paddr == exec_pkg::OFS_CTRL) || (i_paddr == exec_pkg::OFS_PC)
                 || (i_paddr == exec_pkg::OFS_FLAGS) || (i_paddr == exec_pkg::OFS_STAT);
    assign k_ext  = {{(PC_W-7){i_offset[6]}}, i_offset};
    assign diff   = {1'b0, i_reg_data} - {1'b0, i_imm};

    // ------------------------------------------------------------------
    // Branch and skip conditions
    // ------------------------------------------------------------------
    always_comb begin
        br_op   = 1'b1;
        br_cond = 1'b0;
        unique case (i_op)
            exec_pkg::branch_flag_one:       br_cond = o_flags[i_bit_sel];
            exec_pkg::branch_flag_zero:      br_cond = ~o_flags[i_bit_sel];
            exec_pkg::branch_equal:          br_cond = o_flags[exec_pkg::FLAG_Z];
            exec_pkg::branch_not_equal:      br_cond = ~o_flags[exec_pkg::FLAG_Z];
            exec_pkg::branch_carry_one,
            exec_pkg::branch_lower:          br_cond = o_flags[exec_pkg::FLAG_C];
            exec_pkg::branch_carry_zero,
            exec_pkg::branch_same_higher:    br_cond = ~o_flags[exec_pkg::FLAG_C];
            exec_pkg::branch_minus:          br_cond = o_flags[exec_pkg::FLAG_N];
            exec_pkg::branch_plus:           br_cond = ~o_flags[exec_pkg::FLAG_N];
            // Signed compare via N xor V
            exec_pkg::branch_signed_ge:
                br_cond = ~(o_flags[exec_pkg::FLAG_N] ^ o_flags[exec_pkg::FLAG_V]);
            exec_pkg::branch_signed_less:
                br_cond = o_flags[exec_pkg::FLAG_N] ^ o_flags[exec_pkg::FLAG_V];
            exec_pkg::branch_halfcarry_one:  br_cond = o_flags[exec_pkg::FLAG_H];
            exec_pkg::branch_halfcarry_zero: br_cond = ~o_flags[exec_pkg::FLAG_H];
            exec_pkg::branch_xfer_one:       br_cond = o_flags[exec_pkg::FLAG_T];
            exec_pkg::branch_xfer_zero:      br_cond = ~o_flags[exec_pkg::FLAG_T];
            exec_pkg::branch_overflow_one:   br_cond = o_flags[exec_pkg::FLAG_V];
            exec_pkg::branch_int_on:         br_cond = o_flags[exec_pkg::FLAG_I];
            exec_pkg::branch_int_off:        br_cond = ~o_flags[exec_pkg::FLAG_I];
            default:                         br_op   = 1'b0;
        endcase
    end

    always_comb begin
        sk_op   = 1'b1;
        sk_cond = 1'b0;
        unique case (i_op)
            exec_pkg::skip_reg_bit_low:  sk_cond = ~i_reg_data[i_bit_sel];
            exec_pkg::skip_reg_bit_high: sk_cond = i_reg_data[i_bit_sel];
            exec_pkg::skip_io_bit_low:   sk_cond = ~i_io_rdata[i_bit_sel];
            exec_pkg::skip_io_bit_high:  sk_cond = i_io_rdata[i_bit_sel];
            default:                     sk_op   = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Results, flags and counter
    // ------------------------------------------------------------------
    always_comb begin
        flags_d    = o_flags;
        res_d      = i_reg_data;
        rf_we_d    = 1'b0;
        io_we_d    = 1'b0;
        io_wdata_d = i_io_rdata;
        pc_d       = o_pc + PC_W'(1);
        cyc_d      = exec_pkg::CYC_ONE;
        if (br_op && br_cond) begin
            pc_d  = o_pc + k_ext + PC_W'(1);
            cyc_d = exec_pkg::CYC_TWO;
        end else if (sk_op && sk_cond) begin
            pc_d  = o_pc + (i_next_two_word ? PC_W'(3) : PC_W'(2));
            cyc_d = i_next_two_word ? exec_pkg::CYC_THREE : exec_pkg::CYC_TWO;
        end
        unique case (i_op)
            exec_pkg::compare_immediate: begin
                res_d                     = diff[7:0];
                flags_d[exec_pkg::FLAG_C] = diff[8];
                flags_d[exec_pkg::FLAG_H] = (~i_reg_data[3] & i_imm[3])
                    | (i_imm[3] & diff[3]) | (diff[3] & ~i_reg_data[3]);
                flags_d[exec_pkg::FLAG_V] = (i_reg_data[7] & ~i_imm[7] & ~diff[7])
                    | (~i_reg_data[7] & i_imm[7] & diff[7]);
            end
            // Set port bit, read modify write
            exec_pkg::io_bit_force_one: begin
                io_we_d               = 1'b1;
                io_wdata_d[i_bit_sel] = 1'b1;
                cyc_d                 = exec_pkg::CYC_TWO;
            end
            exec_pkg::io_bit_force_zero: begin
                io_we_d               = 1'b1;
                io_wdata_d[i_bit_sel] = 1'b0;
                cyc_d                 = exec_pkg::CYC_TWO;
            end
            exec_pkg::shift_left_logical: begin
                res_d                     = {i_reg_data[6:0], 1'b0};
                flags_d[exec_pkg::FLAG_C] = i_reg_data[7];
            end
            exec_pkg::shift_right_logical: begin
                res_d                     = {1'b0, i_reg_data[7:1]};
                flags_d[exec_pkg::FLAG_C] = i_reg_data[0];
            end
            exec_pkg::rotate_left_carry: begin
                res_d                     = {i_reg_data[6:0], o_flags[exec_pkg::FLAG_C]};
                flags_d[exec_pkg::FLAG_C] = i_reg_data[7];
            end
            exec_pkg::rotate_right_carry: begin
                res_d                     = {o_flags[exec_pkg::FLAG_C], i_reg_data[7:1]};
                flags_d[exec_pkg::FLAG_C] = i_reg_data[0];
            end
            exec_pkg::shift_right_arith: begin
                res_d                     = {i_reg_data[7], i_reg_data[7:1]};
                flags_d[exec_pkg::FLAG_C] = i_reg_data[0];
            end
            exec_pkg::swap_nibbles:    res_d = {i_reg_data[3:0], i_reg_data[7:4]};
            exec_pkg::flag_force_one:  flags_d[i_bit_sel] = 1'b1;
            exec_pkg::flag_force_zero: flags_d[i_bit_sel] = 1'b0;
            exec_pkg::reg_bit_to_xfer: flags_d[exec_pkg::FLAG_T] = i_reg_data[i_bit_sel];
            exec_pkg::xfer_to_reg_bit: res_d[i_bit_sel] = o_flags[exec_pkg::FLAG_T];
            default: ;
        endcase
        // Shared Z N S update for compare and the shifts; V here for the shifts only
        if (i_op inside {exec_pkg::compare_immediate, exec_pkg::shift_left_logical,
                exec_pkg::shift_right_logical, exec_pkg::rotate_left_carry,
                exec_pkg::rotate_right_carry, exec_pkg::shift_right_arith}) begin
            flags_d[exec_pkg::FLAG_Z] = (res_d == 8'h00);
            flags_d[exec_pkg::FLAG_N] = res_d[7];
            if (i_op != exec_pkg::compare_immediate) begin
                flags_d[exec_pkg::FLAG_V] = res_d[7] ^ flags_d[exec_pkg::FLAG_C];
            end
            flags_d[exec_pkg::FLAG_S] = flags_d[exec_pkg::FLAG_N] ^ flags_d[exec_pkg::FLAG_V];
            rf_we_d = (i_op != exec_pkg::compare_immediate);
        end
        if (i_op inside {exec_pkg::swap_nibbles, exec_pkg::xfer_to_reg_bit}) begin
            rf_we_d = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Execution state
    // ------------------------------------------------------------------
    // Issue wins over a software write in the same cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_pc <= '0;
        end else if (iss) begin
            o_pc <= pc_d;
        end else if (apb_wr && i_paddr == exec_pkg::OFS_PC) begin
            o_pc <= i_pwdata[PC_W-1:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_flags <= exec_pkg::FLAGS_RST;
        end else if (iss) begin
            o_flags <= flags_d;
        end else if (apb_wr && i_paddr == exec_pkg::OFS_FLAGS) begin
            o_flags <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_rf_we    <= 1'b0;
            o_rf_wdata <= 8'h00;
            o_io_we    <= 1'b0;
            o_io_wdata <= 8'h00;
        end else begin
            o_rf_we <= iss & rf_we_d;
            o_io_we <= iss & io_we_d;
            if (iss) begin
                o_rf_wdata <= res_d;
                o_io_wdata <= io_wdata_d;
            end
        end
    end

    // Ready drops for the extra cycles of multi-cycle instructions
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            rem_q     <= 2'h0;
            o_ready   <= 1'b1;
            o_cycles  <= 2'h0;
            last_op_q <= exec_pkg::op_nop;
        end else if (iss) begin
            rem_q     <= cyc_d - exec_pkg::CYC_ONE;
            o_ready   <= (cyc_d == exec_pkg::CYC_ONE);
            o_cycles  <= cyc_d;
            last_op_q <= i_op;
        end else if (rem_q != 2'h0) begin
            rem_q   <= rem_q - 2'h1;
            o_ready <= (rem_q == 2'h1);
        end
    end

    // ------------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            en_q <= exec_pkg::CTRL_RST;
        end else if (apb_wr && i_paddr == exec_pkg::OFS_CTRL) begin
            en_q <= i_pwdata[exec_pkg::CTRL_EN_POS];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else begin
            o_pready  <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & ~mapped;
            o_prdata  <= 32'h0000_0000;
            if (i_psel && !i_penable && !i_pwrite) begin
                unique case (i_paddr)
                    exec_pkg::OFS_CTRL:  o_prdata <= {31'h0, en_q};
                    exec_pkg::OFS_PC:    o_prdata <= {{(32-PC_W){1'b0}}, o_pc};
                    exec_pkg::OFS_FLAGS: o_prdata <= {24'h0, o_flags};
                    exec_pkg::OFS_STAT:
                        o_prdata <= {23'h0, o_ready, last_op_q, o_cycles};
                    default:             o_prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    a_cmp_zero_flag: assert property (
        iss && i_op == exec_pkg::compare_immediate |=>
            o_ready && !o_rf_we && o_flags[exec_pkg::FLAG_Z] == ($past(i_reg_data) == $past(i_imm)))
        else $error("compare immediate flag or timing wrong");

    a_skip_reg_pc: assert property (
        iss && i_op == exec_pkg::skip_reg_bit_low && !i_reg_data[i_bit_sel] |=>
            o_pc == $past(o_pc) + ($past(i_next_two_word) ? PC_W'(3) : PC_W'(2)))
        else $error("register skip counter wrong");

    a_skip_io_flags: assert property (
        iss && i_op inside {exec_pkg::skip_io_bit_low, exec_pkg::skip_io_bit_high} |=>
            $stable(o_flags))
        else $error("I/O skip changed flags");

    a_branch_taken_time: assert property (
        iss && i_op == exec_pkg::branch_flag_one && o_flags[i_bit_sel] |=>
            !o_ready ##1 o_ready)
        else $error("taken branch not two cycles");

    a_branch_clear_seq: assert property (
        iss && i_op == exec_pkg::branch_flag_zero && o_flags[i_bit_sel] |=>
            o_ready && o_pc == $past(o_pc) + PC_W'(1) && $stable(o_flags))
        else $error("untaken branch not sequential");

    a_branch_equal_pc: assert property (
        iss && i_op == exec_pkg::branch_equal && o_flags[exec_pkg::FLAG_Z] |=>
            o_pc == $past(o_pc) + {{(PC_W-7){$past(i_offset[6])}}, $past(i_offset)} + PC_W'(1))
        else $error("equal branch target wrong");

    a_signed_less: assert property (
        iss && i_op == exec_pkg::branch_signed_less
            && (o_flags[exec_pkg::FLAG_N] == o_flags[exec_pkg::FLAG_V]) |=>
            o_pc == $past(o_pc) + PC_W'(1))
        else $error("signed less branched wrongly");

    a_io_set_bit: assert property (
        iss && i_op == exec_pkg::io_bit_force_one |=>
            o_io_we && o_io_wdata == ($past(i_io_rdata) | (8'h01 << $past(i_bit_sel)))
            && !o_ready ##1 o_ready && !o_io_we)
        else $error("I/O bit set wrong");

    a_rotate_left: assert property (
        iss && i_op == exec_pkg::rotate_left_carry |=>
            o_rf_we && o_rf_wdata[0] == $past(o_flags[exec_pkg::FLAG_C])
            && o_flags[exec_pkg::FLAG_C] == $past(i_reg_data[7]))
        else $error("rotate left wrong");

    a_bit_store: assert property (
        iss && i_op == exec_pkg::reg_bit_to_xfer |=>
            o_flags[exec_pkg::FLAG_T] == $past(i_reg_data[i_bit_sel]) && o_ready)
        else $error("bit store wrong");

endmodule : branch_skip_bit_shift_exec

`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the branch, skip, bit and shift unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic          clk = 0, rst = 1, issue = 0, two = 0, t, psel = 0, pen = 0, pwr = 0;
    logic          ready, rfwe, iowe, pready, perr, serr;
    exec_pkg::op_t op = exec_pkg::op_nop;
    logic [2:0]    sel = 0;
    logic [7:0]    rd = 0, imm = 0, iod = 0, rfd, iowd, flags;
    logic [6:0]    k = 0;
    logic [11:0]   pa = 0;
    logic [31:0]   pwd = 0, rdv, prd;
    logic [15:0]   pc, epc;
    logic [1:0]    cyc;
    int            err_count = 0, samples_checked = 0;
    logic [7:0]    pats [3] = '{8'h00, 8'hFF, 8'h08};
    exec_pkg::op_t sops [6] = '{exec_pkg::shift_left_logical, exec_pkg::shift_right_logical,
        exec_pkg::rotate_left_carry, exec_pkg::rotate_right_carry,
        exec_pkg::shift_right_arith, exec_pkg::swap_nibbles};
    logic [8:0]    sres [6] = '{9'h082, 9'h120, 9'h083, 9'h1A0, 9'h120, 9'h114};

    branch_skip_bit_shift_exec branch_skip_bit_shift_exec_i (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_issue(issue), .i_op(op), .i_bit_sel(sel),
        .i_reg_data(rd), .i_imm(imm), .i_offset(k), .i_next_two_word(two),
        .i_io_rdata(iod), .o_ready(ready), .o_rf_we(rfwe), .o_rf_wdata(rfd),
        .o_io_we(iowe), .o_io_wdata(iowd), .o_pc(pc), .o_flags(flags), .o_cycles(cyc),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
        .o_prdata(prd), .o_pready(pready), .o_pslverr(perr));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic complete_run(input bit hung);
        if (hung) err_count++;
        $display("Mismatches %0d of %0d compares", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run

    // Wide enough for the error flag plus the read word
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr  <= w;
        pa   <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) complete_run(1);
        rdv = prd;
        serr = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    // Waits for ready, issues one op, then looks 1 ns after the taking edge
    task automatic run(input exec_pkg::op_t o, input logic [2:0] s, input logic [7:0] r);
        int n = 0;
        while (ready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20) complete_run(1);
        @(posedge clk);
        op    <= o;
        sel   <= s;
        rd    <= r;
        issue <= 1'b1;
        @(posedge clk);
        issue <= 1'b0;
        #1;
    endtask : run

    function automatic logic taken(input exec_pkg::op_t o, input logic [7:0] f,
                                   input logic [2:0] s);
        logic b;
        case (o)
            exec_pkg::branch_flag_one, exec_pkg::branch_flag_zero: b = f[s];
            exec_pkg::branch_equal, exec_pkg::branch_not_equal: b = f[exec_pkg::FLAG_Z];
            exec_pkg::branch_minus, exec_pkg::branch_plus: b = f[exec_pkg::FLAG_N];
            exec_pkg::branch_signed_ge, exec_pkg::branch_signed_less:
                b = f[exec_pkg::FLAG_N] ^ f[exec_pkg::FLAG_V];
            exec_pkg::branch_halfcarry_one, exec_pkg::branch_halfcarry_zero: b = f[5];
            exec_pkg::branch_xfer_one, exec_pkg::branch_xfer_zero: b = f[exec_pkg::FLAG_T];
            exec_pkg::branch_overflow_one: b = f[exec_pkg::FLAG_V];
            exec_pkg::branch_int_on, exec_pkg::branch_int_off: b = f[exec_pkg::FLAG_I];
            default: b = f[exec_pkg::FLAG_C];
        endcase
        return b == (o inside {exec_pkg::branch_flag_one, exec_pkg::branch_equal,
            exec_pkg::branch_carry_one, exec_pkg::branch_lower, exec_pkg::branch_minus,
            exec_pkg::branch_signed_less, exec_pkg::branch_halfcarry_one,
            exec_pkg::branch_xfer_one, exec_pkg::branch_overflow_one,
            exec_pkg::branch_int_on});
    endfunction : taken

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, exec_pkg::OFS_CTRL, 32'h0);
        chk(rdv, 32'h1);
        k <= 7'h7C;
        foreach (pats[j]) for (int i = 6; i <= 24; i++) begin
            apb(1'b1, exec_pkg::OFS_FLAGS, {24'h0, pats[j]});
            apb(1'b1, exec_pkg::OFS_PC, 32'h0100);
            t = taken(exec_pkg::op_t'(i), pats[j], 3'(i));
            run(exec_pkg::op_t'(i), 3'(i), 8'h00);
            chk(pc, t ? 16'h00FD : 16'h0101);
            chk(cyc, t ? exec_pkg::CYC_TWO : exec_pkg::CYC_ONE);
            chk({ready, flags}, {!t, pats[j]});
        end
        // Skip cases over both widths of the next instruction
        iod <= 8'h0F;
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, exec_pkg::OFS_PC, 32'h0010);
            two <= i[2];
            t = iod[3'(i * 3)] == i[0];
            run(exec_pkg::op_t'(2 + i[1:0]), 3'(i * 3), 8'h0F);
            chk(cyc, t ? 2'(2 + i[2]) : 2'h1);
            chk(pc, 16'h0010 + (t ? 16'(2 + i[2]) : 16'h1));
        end
        // Shifts, rotates and swap from carry set
        foreach (sops[i]) begin
            apb(1'b1, exec_pkg::OFS_FLAGS, 32'h01);
            run(sops[i], 3'h0, 8'h41);
            chk({rfwe, flags[0], rfd}, {1'b1, sres[i]});
        end
        apb(1'b1, exec_pkg::OFS_FLAGS, 32'h00);
        imm <= 8'h20;
        run(exec_pkg::compare_immediate, 3'h0, 8'h10);
        chk({rfwe, flags[5:0]}, 7'h15);
        imm <= 8'h01;
        run(exec_pkg::compare_immediate, 3'h0, 8'h80);
        chk({cyc, flags[5:0]}, 8'h78);
        iod <= 8'h5A;
        run(exec_pkg::io_bit_force_one, 3'h0, 8'h00);
        chk({iowe, iowd, cyc, ready}, 12'hADC);
        run(exec_pkg::io_bit_force_zero, 3'h1, 8'h00);
        chk({iowe, iowd, flags}, 17'h15838);
        apb(1'b1, exec_pkg::OFS_FLAGS, 32'h00);
        run(exec_pkg::reg_bit_to_xfer, 3'h4, 8'h10);
        chk(flags, 8'h40);
        run(exec_pkg::xfer_to_reg_bit, 3'h3, 8'h00);
        chk({rfwe, rfd, flags}, 17'h10840);
        run(exec_pkg::flag_force_one, 3'h7, 8'h00);
        run(exec_pkg::flag_force_zero, 3'h6, 8'h00);
        chk(flags, 8'h80);
        // Disabled unit ignores issue; status and unmapped reads
        apb(1'b1, exec_pkg::OFS_CTRL, 32'h0);
        epc = pc;
        run(exec_pkg::op_nop, 3'h0, 8'h00);
        chk(pc, epc);
        apb(1'b1, exec_pkg::OFS_CTRL, 32'h1);
        run(exec_pkg::op_nop, 3'h0, 8'h00);
        chk(pc, epc + 16'h1);
        apb(1'b0, exec_pkg::OFS_STAT, 32'h0);
        chk(rdv, 32'h101);
        apb(1'b0, 12'h010, 32'h0);
        chk({serr, rdv}, 33'h100000000);
        complete_run(0);
    end
endmodule : testbench
`default_nettype wire
